// ### external_memory_bus_ctl.v
// external_memory_bus_ctl: multiplexed external memory bus controller
// assumes core requests and register strobes on mclk_in; memory data
// pins are asynchronous and pass a two-flop synchroniser
//
// Summary of operation
// - twenty lines, sixteen shared, eight control
// - control bits: ale oe wrl wrh ba0 ce lb ub
// - internal-only mode ignores control register writes
// - release clear: bus owns pins always, except in internal-only mode
// - release set: pins I/O except accesses, shared mode only
// - control register resets to zero
// - delay field adds zero to three cycles
// - word mode pairs bytes, wrh on odd
// - byte select: byte doubled, wrh plus enable
// - byte write: byte doubled, wrh or wrl
// - write mode ignored in 8-bit width
// - data width setting, set means 16-bit
// - widths fixed by configuration, not software
// - address width frees unused high lines
// - narrow address hides upper data bits
// - byte address output is address lsb
// - byte enables select byte in word
// - 21-bit byte addressing where supported
// - delay only with wait enable, on table reads and writes
// - idle bus: lines floated, strobes inactive
// - byte write strobe chosen by pointer lsb
// - word mode even write only latches
//
// The address-and-strobe port and the address map are this design's own decisions.
`include "ext_bus_defines.vh"

module external_memory_bus_ctl #(
  parameter TW = 4
) (
  input wire mclk_in,
  input wire reset_n_in,
  // configuration, caught while reset is held
  input wire cfg_data16_in,
  input wire [1:0] cfg_addr_width_in,
  input wire cfg_wait_en_in,
  input wire [1:0] cfg_pm_mode_in,
  // core side
  input wire exec_internal_in,
  input wire req_in,
  input wire [1:0] req_kind_in,
  input wire [20:0] table_pointer_in,
  input wire [7:0] table_latch_in,
  output reg busy_out,
  output reg done_out,
  output reg [15:0] rdata_out,
  // register port
  input wire [1:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  // memory pins
  input wire [15:0] bus_in,
  output reg [19:0] bus_out,
  output reg [19:0] bus_oe_out,
  output reg [19:0] line_own_out,
  output reg [7:0] ctl_out,
  output reg [7:0] ctl_oe_out
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_DATA = 3'h2;
  localparam [2:0] ST_HOLD = 3'h3;

  // lines that the configured address width keeps on the bus
  function [19:0] line_mask;
    input [1:0] aw;
    begin
      case (aw)
        `AW_8: line_mask = 20'h000FF;
        `AW_12: line_mask = 20'h00FFF;
        `AW_16: line_mask = 20'h0FFFF;
        default: line_mask = 20'hFFFFF;
      endcase
    end
  endfunction

  // data phase length less one, in clocks; cut to the timer width
  function [TW-1:0] phase_len;
    input [1:0] waits;
    reg [31:0] len;
    begin
      len = (`DATA_MIN_CLKS - 1) + waits * `TCY_CLKS;
      phase_len = len[TW-1:0];
    end
  endfunction

  // a data word on the shared lines, address-only lines left low
  function [19:0] data_lines;
    input [7:0] hi;
    input [7:0] lo;
    begin
      data_lines = {4'h0, hi, lo};
    end
  endfunction

  reg [7:0] ctrl_r;
  reg cfg_data16_r;
  reg [1:0] cfg_aw_r;
  reg cfg_wait_en_r;
  reg [1:0] cfg_pm_r;
  reg release_eff_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [1:0] kind_r;
  reg [20:0] ptr_r;
  reg [7:0] wbyte_r;
  reg [7:0] hold_byte_r;
  reg [19:0] bus_nxt;
  reg [19:0] drive_nxt;
  reg [7:0] ctl_nxt;
  reg timer_load;
  reg [TW-1:0] data_len;
  wire timer_zero;
  wire [15:0] bus_sync;
  wire [19:0] aw_mask;
  wire [15:0] data_mask;
  wire is_write;
  wire word_mode;
  wire bus_owned;
  wire req_ok;
  wire [1:0] delay_tcy;
  wire table_op;

  assign aw_mask = line_mask(cfg_aw_r);
  // upper data bits vanish when the address width is narrow
  assign data_mask = (cfg_data16_r ? 16'hFFFF : 16'h00FF) & aw_mask[15:0];
  assign is_write = (kind_r == `ACC_TBL_WR);
  assign word_mode = ctrl_r[`CTRL_WMODE_HI];
  // fetches run at full speed; only table reads and writes wait
  assign table_op = (kind_r != `ACC_FETCH);
  // encodings 11..00 give 0..3 instruction cycles
  assign delay_tcy = (cfg_wait_en_r && table_op) ? ~ctrl_r[`CTRL_DELAY_HI:`CTRL_DELAY_LO] : 2'h0;
  assign req_ok = req_in && (state_r == ST_IDLE) && (cfg_pm_r != `PM_INTERNAL)
                  && (req_kind_in != 2'h3);
  // ownership of the pin group against port and peripheral functions
  assign bus_owned = (cfg_pm_r == `PM_EXTERNAL) ||
                     ((cfg_pm_r == `PM_SHARED) &&
                      (!release_eff_r || (state_r != ST_IDLE)));

  // configuration is caught only while reset is held
  always @(posedge mclk_in) begin
    if (!reset_n_in) begin
      cfg_data16_r <= cfg_data16_in;
      cfg_aw_r <= cfg_addr_width_in;
      cfg_wait_en_r <= cfg_wait_en_in;
      cfg_pm_r <= cfg_pm_mode_in;
    end
  end

  // control register and register reads
  always @(posedge mclk_in) begin
    if (!reset_n_in) begin
      ctrl_r <= `CTRL_RESET;
      reg_rdata_out <= 8'h00;
    end else begin
      if (reg_wr_in && (reg_addr_in == `REG_CTRL_OFS) &&
          (cfg_pm_r != `PM_INTERNAL)) begin
        ctrl_r <= reg_wdata_in & `CTRL_WR_MASK;
      end
      if (reg_rd_in) begin
        case (reg_addr_in)
          `REG_CTRL_OFS: reg_rdata_out <= ctrl_r;
          `REG_STAT_OFS: reg_rdata_out <= {1'b0, cfg_wait_en_r, cfg_aw_r, cfg_data16_r,
                                           bus_owned, release_eff_r, busy_out};
          default: reg_rdata_out <= 8'h00;
        endcase
      end else begin
        reg_rdata_out <= 8'h00;
      end
    end
  end

  // setting release waits until execution is internal; clearing is at once
  always @(posedge mclk_in) begin
    if (!reset_n_in) begin
      release_eff_r <= 1'b0;
    end else begin
      release_eff_r <= ctrl_r[`CTRL_RELEASE_BIT] && (release_eff_r || exec_internal_in);
    end
  end

  pin_sync2 #(
    .W(16)
  ) u_sync (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .pin_in(bus_in),
    .sync_out(bus_sync)
  );

  phase_timer #(
    .W(TW)
  ) u_timer (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .load_in(timer_load),
    .count_in(data_len),
    .zero_out(timer_zero)
  );

  // data phase length less one, in clocks
  always @* begin
    data_len = phase_len(delay_tcy);
  end

  // cycle sequencing: address, data, hold
  always @* begin
    state_nxt = state_r;
    timer_load = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (req_ok) begin
          state_nxt = ST_ADDR;
        end
      end
      ST_ADDR: begin
        state_nxt = ST_DATA;
        timer_load = 1'b1;
      end
      ST_DATA: begin
        if (timer_zero) begin
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk_in) begin
    if (!reset_n_in) begin
      state_r <= ST_IDLE;
      kind_r <= `ACC_FETCH;
      ptr_r <= 21'h000000;
      wbyte_r <= 8'h00;
      hold_byte_r <= 8'h00;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      rdata_out <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      done_out <= (state_r == ST_HOLD);
      busy_out <= (state_nxt != ST_IDLE);
      if (req_ok) begin
        kind_r <= req_kind_in;
        ptr_r <= table_pointer_in;
        wbyte_r <= table_latch_in;
      end
      // even word-mode write only fills the holding latch
      if ((state_r == ST_ADDR) && is_write && cfg_data16_r && word_mode &&
          !ptr_r[0]) begin
        hold_byte_r <= wbyte_r;
      end
      if ((state_r == ST_DATA) && timer_zero && !is_write) begin
        rdata_out <= bus_sync & data_mask;
      end
    end
  end

  // pin values for the present state, registered below
  always @* begin
    bus_nxt = 20'h00000;
    drive_nxt = 20'h00000;
    ctl_nxt = `CTL_IDLE;
    case (state_r)
      ST_ADDR: begin
        // word address on the lines, byte lsb on its own pin
        bus_nxt = ptr_r[20:1];
        drive_nxt = aw_mask;
        ctl_nxt[`PIN_ALE] = 1'b1;
        ctl_nxt[`PIN_CE] = 1'b0;
        ctl_nxt[`PIN_BA0] = ptr_r[0];
      end
      ST_DATA, ST_HOLD: begin
        ctl_nxt[`PIN_CE] = 1'b0;
        ctl_nxt[`PIN_BA0] = ptr_r[0];
        if (!is_write) begin
          ctl_nxt[`PIN_OE] = (state_r == ST_HOLD);
          if (cfg_data16_r) begin
            ctl_nxt[`PIN_LB] = 1'b0;
            ctl_nxt[`PIN_UB] = 1'b0;
          end
        end else if (!cfg_data16_r) begin
          // write mode plays no part in 8-bit width
          bus_nxt = data_lines(8'h00, wbyte_r);
          drive_nxt = {4'h0, data_mask};
          ctl_nxt[`PIN_WRL] = (state_r == ST_HOLD);
        end else if (word_mode) begin
          if (ptr_r[0]) begin
            bus_nxt = data_lines(wbyte_r, hold_byte_r);
            drive_nxt = {4'h0, data_mask};
            ctl_nxt[`PIN_WRH] = (state_r == ST_HOLD);
            ctl_nxt[`PIN_LB] = 1'b0;
            ctl_nxt[`PIN_UB] = 1'b0;
          end
        end else if (ctrl_r[`CTRL_WMODE_HI:`CTRL_WMODE_LO] == `WM_BYTE_SEL) begin
          bus_nxt = data_lines(wbyte_r, wbyte_r);
          drive_nxt = {4'h0, data_mask};
          ctl_nxt[`PIN_WRH] = (state_r == ST_HOLD);
          // pointer lsb picks the byte within the word
          ctl_nxt[`PIN_UB] = !ptr_r[0] || (state_r == ST_HOLD);
          ctl_nxt[`PIN_LB] = ptr_r[0] || (state_r == ST_HOLD);
        end else begin
          bus_nxt = data_lines(wbyte_r, wbyte_r);
          drive_nxt = {4'h0, data_mask};
          // one write strobe, chosen by the pointer lsb
          ctl_nxt[`PIN_WRH] = !ptr_r[0] || (state_r == ST_HOLD);
          ctl_nxt[`PIN_WRL] = ptr_r[0] || (state_r == ST_HOLD);
        end
      end
      default: begin
        bus_nxt = 20'h00000;
      end
    endcase
  end

  // pin registers; released lines are left to the port logic
  always @(posedge mclk_in) begin
    if (!reset_n_in) begin
      bus_out <= 20'h00000;
      bus_oe_out <= 20'h00000;
      line_own_out <= 20'h00000;
      ctl_out <= `CTL_IDLE;
      ctl_oe_out <= 8'h00;
    end else begin
      bus_out <= bus_nxt & aw_mask;
      bus_oe_out <= bus_owned ? (drive_nxt & aw_mask) : 20'h00000;
      line_own_out <= bus_owned ? aw_mask : 20'h00000;
      ctl_out <= ctl_nxt;
      ctl_oe_out <= bus_owned ? 8'hFF : 8'h00;
    end
  end

endmodule // external_memory_bus_ctl

// ### ext_bus_defines.vh
// ext_bus_defines.vh: constants of the external memory bus controller
// definitions only; included by bare name from the controller module only
`ifndef EXT_BUS_DEFINES_VH
`define EXT_BUS_DEFINES_VH

// register offsets on the plain register port
`define REG_CTRL_OFS 2'h0
`define REG_STAT_OFS 2'h1

// ext_bus_control fields
`define CTRL_RELEASE_BIT 7
`define CTRL_DELAY_HI 5
`define CTRL_DELAY_LO 4
`define CTRL_WMODE_HI 1
`define CTRL_WMODE_LO 0
`define CTRL_RESET 8'h00
`define CTRL_WR_MASK 8'hB3

// control pin group, bit positions
`define PIN_ALE 0
`define PIN_OE 1
`define PIN_WRL 2
`define PIN_WRH 3
`define PIN_BA0 4
`define PIN_CE 5
`define PIN_LB 6
`define PIN_UB 7
// strobes high, ale and byte address low
`define CTL_IDLE 8'hEE

// write_mode_sel encodings below word mode (1x)
`define WM_BYTE_WRITE 2'h0
`define WM_BYTE_SEL 2'h1

// addr_width_sel encodings
`define AW_8 2'h0
`define AW_12 2'h1
`define AW_16 2'h2
`define AW_20 2'h3

// program memory modes
`define PM_INTERNAL 2'h0
`define PM_EXTERNAL 2'h1
`define PM_SHARED 2'h2

// access kinds
`define ACC_FETCH 2'h0
`define ACC_TBL_RD 2'h1
`define ACC_TBL_WR 2'h2

// timing: one instruction cycle and the clock period, in ns
`define TCY_NS 100
`define CLK_NS 100
`define TCY_CLKS ((`TCY_NS + `CLK_NS - 1) / `CLK_NS)
// data phase floor: output register plus two-flop input sync
`define DATA_MIN_CLKS 4

`endif

// ### pin_sync2.v
// pin_sync2: two-flop synchroniser for a group of pin inputs
// assumes the bits are sampled as a bus, skew handled by phase length
module pin_sync2 #(
  parameter W = 16
) (
  input wire mclk_in,
  input wire reset_n_in,
  input wire [W-1:0] pin_in,
  output reg [W-1:0] sync_out
);

  reg [W-1:0] meta_r;

  always @(posedge mclk_in) begin
    if (!reset_n_in) begin
      meta_r <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_r <= pin_in;
      sync_out <= meta_r;
    end
  end

endmodule // pin_sync2

// ### phase_timer.v
// phase_timer: down counter timing the data phase of a bus cycle
// assumes load is a one-cycle pulse from the owning state machine
module phase_timer #(
  parameter W = 4
) (
  input wire mclk_in,
  input wire reset_n_in,
  input wire load_in,
  input wire [W-1:0] count_in,
  output wire zero_out
);

  reg [W-1:0] cnt_r;

  always @(posedge mclk_in) begin
    if (!reset_n_in) begin
      cnt_r <= {W{1'b0}};
    end else if (load_in) begin
      cnt_r <= count_in;
    end else if (cnt_r != {W{1'b0}}) begin
      cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign zero_out = (cnt_r == {W{1'b0}});

endmodule // phase_timer

// ### ext_bus_checker_properties.sv
// ext_bus_checker: pin-level properties of the external memory bus controller
// assumes configuration inputs change only while reset is held
module ext_bus_checker #(
  parameter TW = 4
) (
  input wire mclk_in,
  input wire reset_n_in,
  input wire cfg_data16_in,
  input wire [1:0] cfg_addr_width_in,
  input wire [1:0] cfg_pm_mode_in,
  input wire req_in,
  input wire [1:0] req_kind_in,
  input wire busy_out,
  input wire done_out,
  input wire [19:0] bus_oe_out,
  input wire [19:0] line_own_out,
  input wire [7:0] ctl_out,
  input wire [7:0] ctl_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  // lines above the configured address width
  wire [19:0] free_w = cfg_addr_width_in == 2'h0 ? 20'hFFF00 : cfg_addr_width_in == 2'h1 ? 20'hFF000 :
    cfg_addr_width_in == 2'h2 ? 20'hF0000 : 20'h00000;
  a_done_latency: assert property (req_in && !busy_out && req_kind_in != 2'h3 &&
    cfg_pm_mode_in != 2'h0 |-> ##[7:10] done_out) else $error("done late");
  a_ale_single: assert property (ctl_out[0] |=> !ctl_out[0] && !ctl_out[5])
    else $error("ale not single");
  a_ale_owned: assert property (ctl_out[0] |-> ctl_oe_out == 8'hFF && !ctl_out[5]
    && bus_oe_out[7:0] == 8'hFF) else $error("address phase not driven");
  a_read_floats: assert property (!ctl_out[1] |-> ctl_out[3:2] == 2'h3 && bus_oe_out[7:0] == 8'h00)
    else $error("read drives lines");
  a_free_lines: assert property (((bus_oe_out | line_own_out) & free_w) == 20'h0)
    else $error("unused line taken");
  a_byte_en_8bit: assert property (!cfg_data16_in |-> ctl_out[7:6] == 2'h3)
    else $error("byte enable in 8-bit");
  a_idle_after: assert property (done_out |=> ctl_out == 8'hEE && bus_oe_out == 20'h0)
    else $error("bus not idle");
  a_one_strobe: assert property (!ctl_out[2] |-> ctl_out[3])
    else $error("both strobes low");
endmodule // ext_bus_checker

// ### ext_mem_model.sv
// ext_mem_model: far-side memory answering reads from an address pattern
// assumes the controller's registered pins; captures each write strobe
module ext_mem_model (
  input wire mclk_in,
  input wire [19:0] ad_in,
  input wire [19:0] ad_oe_in,
  input wire [7:0] ctl_in,
  output logic [15:0] pins_out,
  output logic [19:0] addr_out,
  output logic ba_out,
  output logic [15:0] wdata_out,
  output logic [7:0] wctl_out,
  output int wcount_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] last_r = 16'h0000;
  logic wr_r = 1'h0;
  wire [15:0] mem_w = {addr_out[7:0] ^ 8'hA5, addr_out[7:0]};
  wire strobe_w = !(ctl_in[2] && ctl_in[3]);
  initial wcount_out = 0;
  // released lines show the inverse of their last level, memory data while oe is low
  always_comb
    for (int i = 0; i < 16; i++)
      pins_out[i] = ad_oe_in[i] ? ad_in[i] : (ctl_in[1] ? ~last_r[i] : mem_w[i]);
  always @(posedge mclk_in) begin
    last_r <= pins_out;
    wr_r <= strobe_w;
    if (ctl_in[0]) begin
      addr_out <= ad_in;
      ba_out <= ctl_in[4];
    end
    if (strobe_w) begin
      wdata_out <= pins_out;
      wctl_out <= ctl_in;
      if (!wr_r)
        wcount_out <= wcount_out + 1;
    end
  end
endmodule // ext_mem_model

// ### test_external_memory_bus_ctl.sv
// test_external_memory_bus_ctl: self-checking bench of the bus controller
// assumes ext_mem_model on the pins and the checker bound at the foot
module test_external_memory_bus_ctl;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in = 1'h0, reset_n_in = 1'h0, cfg_data16_in = 1'h1, cfg_wait_en_in = 1'h1, ba;
  logic exec_internal_in = 1'h0, req_in = 1'h0, reg_wr_in = 1'h0, reg_rd_in = 1'h0, busy_out, done_out;
  logic [1:0] cfg_addr_width_in = 2'h3, cfg_pm_mode_in = 2'h2, req_kind_in = 2'h0, reg_addr_in = 2'h0;
  logic [20:0] table_pointer_in = 21'h0, pt;
  logic [7:0] table_latch_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, ctl_out, ctl_oe_out, wc, b, lat;
  logic [15:0] rdata_out, bus_in, wd;
  logic [19:0] bus_out, bus_oe_out, line_own_out, ma;
  int miscompares = 0, check_count = 0, cyc = 0, wn, n0, t;
  always #50 mclk_in = ~mclk_in;
  external_memory_bus_ctl #(.TW(4)) external_memory_bus_ctl_i (.*);
  ext_mem_model ext_mem_model_i (.mclk_in, .ad_in(bus_out), .ad_oe_in(bus_oe_out), .ctl_in(ctl_out),
    .pins_out(bus_in), .addr_out(ma), .ba_out(ba), .wdata_out(wd), .wctl_out(wc), .wcount_out(wn));
  task complete_run();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task chk(input logic [20:0] seen, input logic [20:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] exp_rd(input logic [20:0] p);
    return {p[8:1] ^ 8'hA5, p[8:1]};
  endfunction
  task boot(input logic d16, input logic [1:0] aw, input logic [1:0] pm, input logic we);
    reset_n_in <= 1'h0;
    exec_internal_in <= 1'h0;
    cfg_data16_in <= d16;
    cfg_addr_width_in <= aw;
    cfg_pm_mode_in <= pm;
    cfg_wait_en_in <= we;
    repeat (12) @(posedge mclk_in);
    reset_n_in <= 1'h1;
    @(posedge mclk_in);
  endtask
  task wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'h1;
    @(posedge mclk_in);
    reg_wr_in <= 1'h0;
  endtask
  task rd(input logic [1:0] a, input logic [7:0] e);
    reg_addr_in <= a;
    reg_rd_in <= 1'h1;
    @(posedge mclk_in);
    reg_rd_in <= 1'h0;
    @(negedge mclk_in);
    chk(reg_rdata_out, e);
    @(posedge mclk_in);
  endtask
  // returns cycles from request to done, 40 when never answered
  task acc(input logic [1:0] k, input logic [20:0] p, input logic [7:0] d, output int n);
    @(posedge mclk_in);
    req_kind_in <= k;
    table_pointer_in <= p;
    table_latch_in <= d;
    req_in <= 1'h1;
    @(posedge mclk_in);
    req_in <= 1'h0;
    @(posedge mclk_in);
    n = 2;
    chk(busy_out, 1'h1);
    while (done_out !== 1'h1 && n < 40) begin
      @(posedge mclk_in);
      n++;
    end
  endtask
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(39));
    boot(1'h1, 2'h3, 2'h2, 1'h1);
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h7C);
    wr(2'h1, 8'h00);
    rd(2'h1, 8'h7C);
    wr(2'h0, 8'hFF);
    rd(2'h0, 8'hB3);
    rd(2'h2, 8'h00);
    for (int d = 0; d < 4; d++) begin
      wr(2'h0, {2'h0, d[1:0], 4'h0});
      pt = 21'($urandom);
      acc(2'h1, pt, 8'h00, t);
      chk(t, 11 - d);
      chk(rdata_out, exp_rd(pt));
      chk({ba, ma}, {pt[0], pt[20:1]});
      acc(2'h0, pt, 8'h00, t);
      chk(t, 8);
      chk(rdata_out, exp_rd(pt));
    end
    for (int m = 0; m < 4; m++) begin
      wr(2'h0, {6'h0C, m[1:0]});
      for (int p = 0; p < 2; p++) begin
        pt = {20'($urandom), p[0]};
        b = 8'($urandom);
        n0 = wn;
        acc(2'h2, pt, b, t);
        if (m > 1 && p == 0) begin
          chk(wn - n0, 0);
          lat = b;
        end else begin
          chk(wn - n0, 1);
          chk(wc[3:2], (m == 0 && p == 0) ? 2'h2 : 2'h1);
          chk(wd, m > 1 ? {b, lat} : {b, b});
          if (m > 0)
            chk(wc[7:6], m > 1 ? 2'h0 : {~p[0], p[0]});
        end
      end
    end
    boot(1'h0, 2'h1, 2'h2, 1'h1);
    wr(2'h0, 8'h32);
    pt = {20'($urandom), 1'h0};
    b = 8'($urandom);
    n0 = wn;
    acc(2'h2, pt, b, t);
    chk(wn - n0, 1);
    chk({wc[7:6], wc[3:2], wd[7:0]}, {4'hE, b});
    acc(2'h1, pt, 8'h00, t);
    chk(t, 8);
    chk(rdata_out[7:0], pt[8:1]);
    boot(1'h1, 2'h3, 2'h0, 1'h1);
    wr(2'h0, 8'h30);
    rd(2'h0, 8'h00);
    boot(1'h1, 2'h2, 2'h2, 1'h0);
    repeat (2) @(posedge mclk_in);
    chk(line_own_out, 21'h0FFFF);
    wr(2'h0, 8'h80);
    exec_internal_in <= 1'h1;
    repeat (3) @(posedge mclk_in);
    chk(line_own_out, 21'h0);
    chk(ctl_oe_out, 21'h0);
    pt = 21'($urandom);
    acc(2'h1, pt, 8'h00, t);
    chk(t, 8);
    chk(rdata_out, exp_rd(pt));
    wr(2'h0, 8'h00);
    repeat (3) @(posedge mclk_in);
    chk(line_own_out, 21'h0FFFF);
    chk(ctl_out, 8'hEE);
    chk(bus_oe_out, 21'h0);
    complete_run();
  end
endmodule // test_external_memory_bus_ctl
bind external_memory_bus_ctl ext_bus_checker #(.TW(TW)) ext_bus_checker_i (.*);
